// ---- tb.sv ----
`timescale 1ns/10ps
module tb;
  import tw_pkg::*;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic        hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        scl_o;
  logic        scl_oe;
  logic        sda_o;
  logic        sda_oe;
  wire         scl_w;
  wire         sda_w;
  logic        m_scl;
  logic        m_sda;
  logic        tb_sda;
  logic [7:0]  tx_byte;
  logic [3:0]  stretch;
  logic [7:0]  rx_byte;
  logic        got_nack;
  logic [7:0]  n_start;
  logic [7:0]  n_stop;
  logic [31:0] st;
  int          n_mismatch;
  int          comparisons;
  logic [16:0] rows [3];

  assign hready = hreadyout;
  assign scl_w  = ~((scl_oe & ~scl_o) | m_scl);
  assign sda_w  = ~((sda_oe & ~sda_o) | m_sda | tb_sda);

  always #20 hclk = ~hclk;

  tw_two_wire_master #(.FILT(1)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl_w),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe)
  );

  tw_slave_model i_slave (
    .hclk(hclk), .scl(scl_w), .sda(sda_w), .tx_byte(tx_byte), .stretch(stretch),
    .scl_pull(m_scl), .sda_pull(m_sda), .rx_byte(rx_byte), .got_nack(got_nack),
    .n_start(n_start), .n_stop(n_stop)
  );

  // ---------------------------------------
  // Bus tasks
  // ---------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic ahb_acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk iff hready === 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= w ? d : 32'h0000_0000;
    @(posedge hclk iff hready === 1'b1);
    st = hrdata;
  endtask

  task automatic op(input logic [31:0] c, input int b);
    int n;
    ahb_acc(1'b1, ADDR_STAT, 32'h0000_0010);
    ahb_acc(1'b1, ADDR_CMD, c);
    n = 0;
    do begin
      ahb_acc(1'b0, ADDR_STAT, 32'h0000_0000);
      n++;
    end while ((st[STAT_BUSY] !== 1'b0 || st[b] !== 1'b1) && n < 3000);
    if (n >= 3000) begin
      n_mismatch++;
      $display("[FAIL] %0t no completion", $time);
    end
  endtask

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #(60000 * 40);
    n_mismatch++;
    $display("[FAIL] %0t timeout", $time);
    test_done();
  end

  // ---------------------------------------
  // Main sequence
  // ---------------------------------------
  initial begin
    logic [7:0] a;
    logic [7:0] d;
    logic       en;
    logic [7:0] s0;
    logic [7:0] p0;
    {hclk, hresetn, hsel, hwrite, tb_sda, htrans, stretch} = '0;
    {haddr, hwdata, tx_byte} = '0;
    n_mismatch = 0;
    comparisons = 0;
    rows = '{{8'h54, 8'ha5, 1'b0}, {8'h54, 8'h01, 1'b0}, {8'h56, 8'h80, 1'b1}};
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    chk({30'h0, scl_oe, sda_oe}, 32'h0000_0000);
    chk({28'h0, hreadyout, hresp, scl_o, sda_o}, 32'h0000_0008);
    ahb_acc(1'b0, ADDR_STAT, 32'h0000_0000);
    chk(st, 32'h0000_0000);
    ahb_acc(1'b0, ADDR_DIV, 32'h0000_0000);
    chk(st, {16'h0000, DIV_RST});
    ahb_acc(1'b0, ADDR_CMD, 32'h0000_0000);
    chk(st, 32'h0000_0000);
    ahb_acc(1'b0, 8'h20, 32'h0000_0000);
    chk(st, 32'h0000_0000);
    ahb_acc(1'b1, ADDR_DIV, 32'h0000_0009);
    ahb_acc(1'b0, ADDR_DIV, 32'h0000_0000);
    chk(st, 32'h0000_0009);
    for (int i = 0; i < 3; i++) begin
      {a, d, en} = rows[i];
      s0 = n_start;
      p0 = n_stop;
      op(32'h0000_0001, STAT_HELD);
      ahb_acc(1'b1, ADDR_TXD, {24'h00_0000, a});
      op(32'h0000_0002, STAT_HELD);
      chk({31'h0, st[STAT_NACK]}, {31'h0, en});
      if (!en) begin
        ahb_acc(1'b1, ADDR_TXD, {24'h00_0000, d});
        op(32'h0000_0002, STAT_HELD);
        chk({24'h00_0000, rx_byte}, {24'h00_0000, d});
      end
      op(32'h0000_0008, STAT_DONE);
      chk({24'h00_0000, 8'(n_start - s0)}, 32'h0000_0001);
      chk({24'h00_0000, 8'(n_stop - p0)}, 32'h0000_0001);
      chk({31'h0, st[STAT_BUSBY]}, 32'h0000_0001);
      repeat (BUF_CYC + 20) @(posedge hclk);
      ahb_acc(1'b0, ADDR_STAT, 32'h0000_0000);
      chk({31'h0, st[STAT_BUSBY]}, 32'h0000_0000);
    end
    stretch <= 4'h3;
    tx_byte <= 8'h3c;
    s0 = n_start;
    op(32'h0000_0001, STAT_HELD);
    ahb_acc(1'b1, ADDR_TXD, 32'h0000_0054);
    op(32'h0000_0002, STAT_HELD);
    op(32'h0000_0001, STAT_HELD);
    ahb_acc(1'b1, ADDR_TXD, 32'h0000_0055);
    op(32'h0000_0002, STAT_HELD);
    chk({31'h0, st[STAT_NACK]}, 32'h0000_0000);
    op(32'h0000_0004, STAT_HELD);
    ahb_acc(1'b0, ADDR_RXD, 32'h0000_0000);
    chk(st, 32'h0000_003c);
    op(32'h0000_0014, STAT_HELD);
    ahb_acc(1'b0, ADDR_RXD, 32'h0000_0000);
    chk(st, 32'h0000_004d);
    op(32'h0000_0008, STAT_DONE);
    chk({31'h0, got_nack}, 32'h0000_0001);
    chk({24'h00_0000, 8'(n_start - s0)}, 32'h0000_0002);
    stretch <= 4'h0;
    op(32'h0000_0001, STAT_HELD);
    ahb_acc(1'b1, ADDR_TXD, 32'h0000_00ff);
    tb_sda <= 1'b1;
    op(32'h0000_0002, STAT_ARB);
    chk({31'h0, st[STAT_ARB]}, 32'h0000_0001);
    chk({30'h0, scl_oe, sda_oe}, 32'h0000_0000);
    tb_sda <= 1'b0;
    op(32'h0000_0001, STAT_HELD);
    ahb_acc(1'b1, ADDR_TXD, 32'h0000_00ff);
    ahb_acc(1'b1, ADDR_CMD, 32'h0000_0002);
    @(posedge scl_w);
    repeat (6) @(posedge hclk);
    tb_sda <= 1'b1;
    repeat (30) @(posedge hclk);
    ahb_acc(1'b0, ADDR_STAT, 32'h0000_0000);
    chk({31'h0, st[STAT_ERR]}, 32'h0000_0001);
    chk({30'h0, scl_oe, sda_oe}, 32'h0000_0000);
    tb_sda <= 1'b0;
    ahb_acc(1'b1, ADDR_STAT, 32'h0000_0070);
    ahb_acc(1'b0, ADDR_STAT, 32'h0000_0000);
    chk({29'h0, st[6:4]}, 32'h0000_0000);
    op(32'h0000_0001, STAT_HELD);
    chk({30'h0, scl_oe, sda_oe}, 32'h0000_0002);
    hresetn <= 1'b0;
    @(posedge hclk);
    chk({30'h0, scl_oe, sda_oe}, 32'h0000_0000);
    hresetn <= 1'b1;
    ahb_acc(1'b0, ADDR_DIV, 32'h0000_0000);
    chk(st, {16'h0000, DIV_RST});
    test_done();
  end
endmodule

// ---- tw_bus_mon.sv ----
`timescale 1ns/10ps
module tw_bus_mon
  import tw_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic scl_f,
  input  wire logic sda_f,
  output logic      bus_busy
);
  // ---------------------------------------------------------------
  // Start and stop detection, bus free timer
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        p_scl;
    logic        p_sda;
    logic        busy;
    logic        freeing;
    logic [15:0] cnt;
  } tw_mon_st_t;

  tw_mon_st_t st;
  tw_mon_st_t next_st;
  logic       start_seen;
  logic       stop_seen;

  always_comb begin
    start_seen    = st.p_sda && !sda_f && scl_f && st.p_scl;
    stop_seen     = !st.p_sda && sda_f && scl_f && st.p_scl;
    next_st       = st;
    next_st.p_scl = scl_f;
    next_st.p_sda = sda_f;
    if (start_seen) begin
      next_st.busy    = 1'b1;
      next_st.freeing = 1'b0;
    end else if (stop_seen) begin
      next_st.freeing = 1'b1;
      next_st.cnt     = BUF_RST;
    end else if (st.freeing) begin
      if (st.cnt == 16'h0000) begin
        next_st.busy    = 1'b0;
        next_st.freeing = 1'b0;
      end else begin
        next_st.cnt = st.cnt - 16'h0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '{p_scl: 1'b1, p_sda: 1'b1, busy: 1'b0, freeing: 1'b0, cnt: 16'h0000};
    end else begin
      st <= next_st;
    end
  end

  assign bus_busy = st.busy;
endmodule

// ---- tw_line_filter.sv ----
`timescale 1ns/10ps
module tw_line_filter
  import tw_pkg::*;
#(
  parameter int FILT = GLITCH_CYC
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic line_in,
  output logic      line_out
);
  // ---------------------------------------------------------------
  // Two-stage sync, then stability filter
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       s1;
    logic       s2;
    logic       out;
    logic [7:0] cnt;
  } tw_filt_st_t;

  tw_filt_st_t st;
  tw_filt_st_t next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = line_in;
    next_st.s2 = st.s1;
    if (st.s2 == st.out) begin
      next_st.cnt = 8'h00;
    end else if (st.cnt >= 8'(FILT)) begin
      next_st.out = st.s2;
      next_st.cnt = 8'h00;
    end else begin
      next_st.cnt = st.cnt + 8'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '{s1: 1'b1, s2: 1'b1, out: 1'b1, cnt: 8'h00};
    end else begin
      st <= next_st;
    end
  end

  assign line_out = st.out;
endmodule

// ---- tw_pkg.sv ----
package tw_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int T_HALF_NS     = 5000;
  localparam int HALF_CYC      = (T_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_BUF_NS      = 4700;
  localparam int BUF_CYC       = (T_BUF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_GLITCH_NS   = 50;
  localparam int GLITCH_CYC    = (T_GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [15:0] DIV_RST = 16'(HALF_CYC - 1);
  localparam logic [15:0] BUF_RST = 16'(BUF_CYC - 1);

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD  = 8'h00;
  localparam logic [7:0] ADDR_TXD  = 8'h04;
  localparam logic [7:0] ADDR_RXD  = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam logic [7:0] ADDR_DIV  = 8'h10;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CMD_START  = 0;
  localparam int CMD_WRITE  = 1;
  localparam int CMD_READ   = 2;
  localparam int CMD_STOP   = 3;
  localparam int CMD_NACK   = 4;

  localparam int STAT_BUSY  = 0;
  localparam int STAT_HELD  = 1;
  localparam int STAT_BUSBY = 2;
  localparam int STAT_NACK  = 3;
  localparam int STAT_DONE  = 4;
  localparam int STAT_ERR   = 5;
  localparam int STAT_ARB   = 6;

  localparam logic [3:0] LAST_BIT = 4'h8;

  // ---------------------------------------------------------------
  // Engine states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_START_A,
    ST_START_B,
    ST_HOLD,
    ST_BIT_LOW,
    ST_BIT_HIGH,
    ST_RS_A,
    ST_RS_B,
    ST_STOP_A,
    ST_STOP_B,
    ST_STOP_C
  } tw_state_t;

endpackage

// ---- tw_slave_model.sv ----
`timescale 1ns/10ps
module tw_slave_model #(
  parameter logic [6:0] ADDR7 = 7'h2a
) (
  input  wire logic       hclk,
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [7:0] tx_byte,
  input  wire logic [3:0] stretch,
  output logic            scl_pull,
  output logic            sda_pull,
  output logic [7:0]      rx_byte,
  output logic            got_nack,
  output logic [7:0]      n_start,
  output logic [7:0]      n_stop
);
  logic       act;
  logic       first;
  logic       rd;
  logic       sel;
  logic [3:0] cnt;
  logic [7:0] sr;
  logic [7:0] tx;

  initial begin
    {scl_pull, sda_pull, got_nack, act, first, rd, sel} = '0;
    {rx_byte, n_start, n_stop, cnt, sr, tx} = '0;
  end

  // ---------------------------------------
  // Start and stop conditions
  // ---------------------------------------
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      act = 1'b1;
      first = 1'b1;
      rd = 1'b0;
      got_nack = 1'b0;
      cnt = 4'h0;
      n_start = n_start + 8'h01;
    end
  end

  always @(posedge sda) begin
    if (scl === 1'b1 && act) begin
      act = 1'b0;
      n_stop = n_stop + 8'h01;
    end
  end

  // ---------------------------------------
  // Bit sampling and driving
  // ---------------------------------------
  always @(posedge scl) begin
    if (act) begin
      if (cnt < 4'h8) sr = {sr[6:0], sda};
      else if (sel && rd && !first) got_nack = sda;
      cnt = cnt + 4'h1;
    end
  end

  always @(negedge scl) begin
    if (act) begin
      scl_pull = (stretch != 4'h0);
      repeat (2 + 4 * stretch) @(posedge hclk);
      if (cnt == 4'h8) begin
        if (first) begin
          sel = (sr[7:1] == ADDR7);
          rd = sr[0];
          tx = tx_byte - 8'h11;
        end else if (sel && !rd) begin
          rx_byte = sr;
        end
        sda_pull = sel && !(rd && !first);
        first = 1'b0;
      end else if (cnt == 4'h9) begin
        cnt = 4'h0;
        if (got_nack) sel = 1'b0;
        tx = tx + 8'h11;
        sda_pull = sel && rd && !tx[7];
      end else begin
        sda_pull = sel && rd && !first && !tx[3'(7 - cnt)];
      end
      repeat (2) @(posedge hclk);
      scl_pull = 1'b0;
    end
  end
endmodule

// ---- tw_two_wire_master.sv ----
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/10ps
// Contract
// - Master starts, clocks and ends each transaction
// - One bit per clock, sampled while high
// - Data changes only while clock low
// - Transaction is start, bytes, then stop
// - Bytes travel most significant bit first
// - Acknowledge bit follows every eight bits
// - Slave may stretch clock low; master waits
// - Start: data falls; stop: data rises, clock high
// - Master may issue repeated start mid-transaction
// - Master gives ninth clock for acknowledge
// - Transmitter releases data during acknowledge clock
// - Receiver pulls data low to acknowledge
// - Master receiver leaves last byte unacknowledged
// - First byte: seven-bit address plus direction
module tw_two_wire_master
  import tw_pkg::*;
#(
  parameter int FILT = GLITCH_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    tw_state_t   state;
    logic [15:0] cnt;
    logic [15:0] div;
    logic [3:0]  bit_cnt;
    logic [7:0]  shift;
    logic [7:0]  txd;
    logic [7:0]  rxd;
    logic        wr;
    logic        nack_mode;
    logic        seen;
    logic        samp;
    logic        scl_drv;
    logic        sda_drv;
    logic        start_pend;
    logic        nack_rx;
    logic        done;
    logic        bus_err;
    logic        arb_lost;
    logic        a_wr;
    logic [7:0]  a_addr;
    logic [31:0] rdata;
  } tw_master_st_t;

  tw_master_st_t st;
  tw_master_st_t next_st;
  logic          scl_f;
  logic          sda_f;
  logic          bus_busy;
  logic [4:0]    cmd;
  logic [2:0]    clr;
  logic          set_done;
  logic          set_err;
  logic          set_arb;
  logic [6:0]    stat;

  function automatic logic [15:0] dec(input logic [15:0] v);
    return v - 16'h0001;
  endfunction

  // ---------------------------------------------------------------
  // Line conditioning and bus monitor
  // ---------------------------------------------------------------
  tw_line_filter #(.FILT(FILT)) u_scl_filt (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .line_in  (scl_i),
    .line_out (scl_f)
  );

  tw_line_filter #(.FILT(FILT)) u_sda_filt (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .line_in  (sda_i),
    .line_out (sda_f)
  );

  tw_bus_mon u_mon (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .scl_f    (scl_f),
    .sda_f    (sda_f),
    .bus_busy (bus_busy)
  );

  // ---------------------------------------------------------------
  // Bus slave, command decode and bit engine
  // ---------------------------------------------------------------
  always_comb begin
    next_st  = st;
    set_done = 1'b0;
    set_err  = 1'b0;
    set_arb  = 1'b0;
    clr      = 3'b000;
    cmd      = 5'b00000;
    stat     = {st.arb_lost, st.bus_err, st.done, st.nack_rx, bus_busy,
                (st.state == ST_HOLD),
                (st.state != ST_IDLE && st.state != ST_HOLD) || st.start_pend};

    next_st.a_wr = 1'b0;
    if (hsel && htrans[1] && hready) begin
      next_st.a_wr   = hwrite;
      next_st.a_addr = haddr[7:0];
      case (haddr[7:0])
        ADDR_TXD:  next_st.rdata = 32'(st.txd);
        ADDR_RXD:  next_st.rdata = 32'(st.rxd);
        ADDR_STAT: next_st.rdata = 32'(stat);
        ADDR_DIV:  next_st.rdata = 32'(st.div);
        default:   next_st.rdata = 32'h0000_0000;
      endcase
    end
    if (st.a_wr) begin
      case (st.a_addr)
        ADDR_CMD:  cmd = hwdata[4:0];
        ADDR_TXD:  next_st.txd = hwdata[7:0];
        ADDR_STAT: clr = hwdata[STAT_ARB:STAT_DONE];
        ADDR_DIV:  next_st.div = hwdata[15:0];
        default:   next_st.rdata = st.rdata;
      endcase
    end

    unique case (st.state)
      ST_IDLE: begin
        next_st.scl_drv = 1'b0;
        next_st.sda_drv = 1'b0;
        if (cmd[CMD_START]) begin
          next_st.start_pend = 1'b1;
        end else if (st.start_pend && !bus_busy) begin
          next_st.start_pend = 1'b0;
          next_st.sda_drv    = 1'b1;
          next_st.cnt        = st.div;
          next_st.state      = ST_START_A;
        end
      end
      ST_START_A: begin
        if (st.cnt == 16'h0000) begin
          next_st.scl_drv = 1'b1;
          next_st.cnt     = st.div;
          next_st.state   = ST_START_B;
        end else begin
          next_st.cnt = dec(st.cnt);
        end
      end
      ST_START_B: begin
        if (st.cnt == 16'h0000) begin
          next_st.state = ST_HOLD;
        end else begin
          next_st.cnt = dec(st.cnt);
        end
      end
      ST_HOLD: begin
        next_st.sda_drv = 1'b0;
        next_st.cnt     = st.div;
        next_st.bit_cnt = 4'h0;
        if (cmd[CMD_START]) begin
          next_st.state = ST_RS_A;
        end else if (cmd[CMD_WRITE]) begin
          next_st.shift = st.txd;
          next_st.wr    = 1'b1;
          next_st.state = ST_BIT_LOW;
        end else if (cmd[CMD_READ]) begin
          next_st.wr        = 1'b0;
          next_st.nack_mode = cmd[CMD_NACK];
          next_st.state     = ST_BIT_LOW;
        end else if (cmd[CMD_STOP]) begin
          next_st.sda_drv = 1'b1;
          next_st.state   = ST_STOP_A;
        end
      end
      ST_BIT_LOW: begin
        if (st.bit_cnt < LAST_BIT) begin
          next_st.sda_drv = st.wr && !st.shift[7];
        end else begin
          next_st.sda_drv = !st.wr && !st.nack_mode;
        end
        if (st.cnt == 16'h0000) begin
          next_st.scl_drv = 1'b0;
          next_st.cnt     = st.div;
          next_st.seen    = 1'b0;
          next_st.state   = ST_BIT_HIGH;
        end else begin
          next_st.cnt = dec(st.cnt);
        end
      end
      ST_BIT_HIGH: begin
        if (!st.seen) begin
          if (scl_f) begin
            next_st.seen = 1'b1;
            next_st.samp = sda_f;
          end
        end else if (sda_f != st.samp) begin
          set_err = 1'b1;
        end else if (st.cnt != 16'h0000) begin
          next_st.cnt = dec(st.cnt);
        end else if (st.bit_cnt < LAST_BIT) begin
          next_st.shift   = {st.shift[6:0], st.samp};
          next_st.bit_cnt = st.bit_cnt + 4'h1;
          next_st.scl_drv = 1'b1;
          next_st.cnt     = st.div;
          next_st.state   = ST_BIT_LOW;
          set_arb         = st.wr && !st.sda_drv && !st.samp;
        end else begin
          if (st.wr) begin
            next_st.nack_rx = st.samp;
          end else begin
            next_st.rxd = st.shift;
          end
          set_done        = 1'b1;
          next_st.scl_drv = 1'b1;
          next_st.state   = ST_HOLD;
        end
      end
      ST_RS_A: begin
        if (st.cnt == 16'h0000) begin
          next_st.scl_drv = 1'b0;
          next_st.seen    = 1'b0;
          next_st.cnt     = st.div;
          next_st.state   = ST_RS_B;
        end else begin
          next_st.cnt = dec(st.cnt);
        end
      end
      ST_RS_B, ST_STOP_B: begin
        if (!st.seen) begin
          next_st.seen = scl_f;
        end else if (st.cnt != 16'h0000) begin
          next_st.cnt = dec(st.cnt);
        end else begin
          next_st.sda_drv = (st.state == ST_RS_B);
          next_st.cnt     = st.div;
          next_st.state   = (st.state == ST_RS_B) ? ST_START_A : ST_STOP_C;
        end
      end
      ST_STOP_A: begin
        if (st.cnt == 16'h0000) begin
          next_st.scl_drv = 1'b0;
          next_st.seen    = 1'b0;
          next_st.cnt     = st.div;
          next_st.state   = ST_STOP_B;
        end else begin
          next_st.cnt = dec(st.cnt);
        end
      end
      ST_STOP_C: begin
        if (st.cnt == 16'h0000) begin
          set_done      = 1'b1;
          next_st.state = ST_IDLE;
        end else begin
          next_st.cnt = dec(st.cnt);
        end
      end
    endcase

    if (set_err || set_arb) begin
      next_st.scl_drv = 1'b0;
      next_st.sda_drv = 1'b0;
      next_st.state   = ST_IDLE;
    end
    next_st.done     = (st.done & ~clr[0]) | set_done;
    next_st.bus_err  = (st.bus_err & ~clr[1]) | set_err;
    next_st.arb_lost = (st.arb_lost & ~clr[2]) | set_arb;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st     <= '0;
      st.div <= DIV_RST;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign hrdata    = st.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;
  assign scl_oe    = st.scl_drv;
  assign sda_oe    = st.sda_drv;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_stop_enter;
    $rose(st.state == ST_STOP_C);
  endsequence

  sequence s_start_enter;
    $rose(st.state == ST_START_A);
  endsequence

  a_sda_low_change: assert property (
    ($changed(st.sda_drv) && st.state != ST_IDLE && st.state != ST_START_A
      && st.state != ST_STOP_C) |-> $past(st.scl_drv))
    else $error("data line changed while clock released");

  a_start_shape: assert property (
    s_start_enter |-> st.sda_drv && !st.scl_drv && !$past(st.sda_drv))
    else $error("start not a falling data line with clock high");

  a_stop_shape: assert property (
    s_stop_enter |-> !st.sda_drv && !st.scl_drv && $past(st.sda_drv))
    else $error("stop not a rising data line with clock high");

  a_msb_first: assert property (
    (st.state == ST_BIT_HIGH && st.wr && st.bit_cnt < LAST_BIT)
      |-> st.sda_drv == !st.shift[7])
    else $error("transmitted bit is not the top shift bit");

  a_ack_release: assert property (
    (st.state == ST_BIT_HIGH && st.wr && st.bit_cnt == LAST_BIT) |-> !st.sda_drv)
    else $error("data line held during acknowledge of sent byte");

  a_ack_drive: assert property (
    (st.state == ST_BIT_HIGH && !st.wr && st.bit_cnt == LAST_BIT)
      |-> st.sda_drv == !st.nack_mode)
    else $error("wrong acknowledge level for received byte");

  a_nine_clocks: assert property (
    (st.state == ST_HOLD && $past(st.state) == ST_BIT_HIGH)
      |-> $past(st.bit_cnt) == LAST_BIT && st.done)
    else $error("byte did not end after nine clocks");

  a_stretch_wait: assert property (
    (st.state == ST_BIT_HIGH && !st.seen && !scl_f)
      |=> st.state == ST_BIT_HIGH && $stable(st.cnt))
    else $error("clock high count ran while clock held low");

  a_start_free: assert property (
    (s_start_enter ##0 $past(st.state) == ST_IDLE) |-> $past(!bus_busy))
    else $error("start issued while bus busy");
endmodule
